// ===== lbhpi_defs.vh
// Constants for the local bus host pin interface
`ifndef LBHPI_DEFS_VH
`define LBHPI_DEFS_VH

// =========================================================
// Timing
// =========================================================
`define LBHPI_CLK_PERIOD_PS    32'd5000
`define LBHPI_RESET_FILTER_PS  32'd100000
`define LBHPI_RESET_FILTER_CYC ((`LBHPI_RESET_FILTER_PS + `LBHPI_CLK_PERIOD_PS - 32'd1) / `LBHPI_CLK_PERIOD_PS)

// =========================================================
// Field positions and widths
// =========================================================
`define LBHPI_ADDR_W           20
`define LBHPI_DATA_W           16
`define LBHPI_BASE_LSB         4
`define LBHPI_BASE_MSB         15
`define LBHPI_REG_IDX_W        3
`define LBHPI_INT_LINES        4

// =========================================================
// Reset values and wait count
// =========================================================
`define LBHPI_BASE_RST         12'h030
`define LBHPI_ROM_BASE_RST     4'hc
`define LBHPI_WAIT_CYC         4'h2

`endif

// ===== lbhpi_reset_filter.v
// Glitch filter for the active-high reset pin
`timescale 1ns/1ps
`include "lbhpi_defs.vh"

module lbhpi_reset_filter #(
  parameter CNT_W = 8
) (
  // Clock and power-on reset
  input  wire clk_i,
  input  wire rst_n_i,
  // Raw pin and filtered result
  input  wire reset_pin_i,
  output reg  reset_o
);

  // =========================================================
  // Synchroniser
  // =========================================================
  reg             sync_a;
  reg             sync_b;
  reg [CNT_W-1:0] cnt;
  localparam [31:0]      FILT_FULL = `LBHPI_RESET_FILTER_CYC;
  localparam [CNT_W-1:0] FILT_CYC  = FILT_FULL[CNT_W-1:0];

  // Two stages; only the second is read
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= reset_pin_i;
      sync_b <= sync_a;
    end
  end

  // =========================================================
  // Width qualifier
  // =========================================================
  // filter short pulses
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt     <= {CNT_W{1'b0}};
      reset_o <= 1'b0;
    end else if (!sync_b) begin
      cnt     <= {CNT_W{1'b0}};
      reset_o <= 1'b0;
    end else if (cnt < FILT_CYC) begin
      cnt <= cnt + {{(CNT_W-1){1'b0}}, 1'b1};
    end else begin
      reset_o <= 1'b1;            // Held long enough
    end
  end

endmodule

// ===== lbhpi_top.v
// Local bus host pin interface: decode, latch, data path, ROM select, interrupts
// Functional notes
// - Sample ROM strap at reset end; high=local
// - Drive ROM select on read of ROM
// - Decode only while address qualifier low
// - Ready pulled low stretches host access
// - Sixteen-bit bidirectional register data path
// - Reset active high, filtered 100ns
// - Latch address, byte enable on strobe fall
// - Interrupt high on one of four outputs
// - Unselected interrupt outputs high impedance
// - Twenty address inputs for decoding
// - Wide cycle indicate on base match
`timescale 1ns/1ps
`include "lbhpi_defs.vh"

module lbhpi_top #(
  parameter ADDR_W = `LBHPI_ADDR_W,
  parameter DATA_W = `LBHPI_DATA_W,
  parameter IDX_W  = `LBHPI_REG_IDX_W
) (
  // Clock and power-on reset
  input  wire              clk_i,
  input  wire              rst_n_i,
  // Reset pin
  input  wire              reset_pin_i,
  // Address and qualifiers
  input  wire [ADDR_W-1:0] addr_i,
  input  wire              address_qualifier_i,
  input  wire              address_latch_strobe_i,
  input  wire              upper_byte_enable_n_i,
  // Strobes
  input  wire              io_read_n_i,
  input  wire              io_write_n_i,
  input  wire              memory_read_strobe_n_i,
  // Data bus, three signals
  input  wire [DATA_W-1:0] data_i,
  output reg  [DATA_W-1:0] data_o,
  output reg               data_oe_o,
  // ROM select strap pin
  input  wire              rom_select_strap_i,
  output reg               rom_select_strap_o,
  output reg               rom_select_strap_oe_o,
  // Open-drain wait and wide cycle
  output reg               channel_ready_out_oe_o,
  output reg               wide_cycle_indicate_n_oe_o,
  // Configuration from the core
  input  wire              wide_mode_i,
  input  wire [11:0]       base_addr_i,
  input  wire [3:0]        rom_base_i,
  input  wire [1:0]        interrupt_line_select_i,
  input  wire              core_irq_i,
  // Interrupt lines with enables
  output reg  [3:0]        interrupt_out_o,
  output reg  [3:0]        interrupt_out_oe_o,
  // Status to the core
  output reg               local_bus_mode_o,
  output reg               chip_reset_o
);

  // =========================================================
  // Pin synchronisers
  // =========================================================
  localparam NSYNC = ADDR_W + DATA_W + 7;
  reg  [NSYNC-1:0] s1;
  reg  [NSYNC-1:0] s2;
  wire [NSYNC-1:0] raw = {addr_i, data_i, address_qualifier_i, address_latch_strobe_i,
                          upper_byte_enable_n_i, io_read_n_i, io_write_n_i,
                          memory_read_strobe_n_i, rom_select_strap_i};

  // Address, data and strobes share one sync depth, so a strobe
  // edge and the data it qualifies arrive on the same cycle
  // Cost: two cycles of latency on every pin path
  // Reset to ones matches the pulled-up idle pins
  // Two-flop chain per pin bit; idle strobes high
  genvar g;
  generate
    for (g = 0; g < NSYNC; g = g + 1) begin : g_sync
      always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          s1[g] <= 1'b1;
          s2[g] <= 1'b1;
        end else begin
          s1[g] <= raw[g];
          s2[g] <= s1[g];
        end
      end
    end
  endgenerate

  // Field order follows the raw concatenation, strap at bit 0
  // twenty address inputs
  wire [ADDR_W-1:0] a_s    = s2[NSYNC-1 -: ADDR_W];
  wire [DATA_W-1:0] d_s    = s2[7 +: DATA_W];
  wire              aen_s  = s2[6];
  wire              ale_s  = s2[5];
  wire              ube_s  = s2[4];
  wire              rd_s   = s2[3];
  wire              wr_s   = s2[2];
  wire              mrd_s  = s2[1];
  wire              strap_s = s2[0];

  // =========================================================
  // Reset filter
  // =========================================================
  wire rst_f;

  // Pulses shorter than the filter never reach the core
  // Power-on reset still acts at once through rst_n_i
  // qualified reset
  lbhpi_reset_filter #(
    .CNT_W (8)
  ) u_rst (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .reset_pin_i (reset_pin_i),
    .reset_o     (rst_f)
  );

  // =========================================================
  // Strap capture
  // =========================================================
  reg rst_q;

  // Captured once per reset, on the cycle the filtered reset drops
  // Power-on default is local bus, as for an open strap pin
  // Strap driver is off during reset, so the board pull is seen
  // strap taken on falling edge of reset
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_q            <= 1'b0;
      chip_reset_o     <= 1'b0;
      local_bus_mode_o <= 1'b1;
    end else begin
      rst_q        <= rst_f;
      chip_reset_o <= rst_f;
      if (rst_q && !rst_f) begin
        local_bus_mode_o <= strap_s;   // Open pin pulls high
      end
    end
  end

  // =========================================================
  // Address latch
  // =========================================================
  reg              ale_q;
  reg [ADDR_W-1:0] a_lat;
  reg              ube_lat;
  reg              lat_valid;
  reg              stb_idle_q;
  wire             stb_idle = rd_s && wr_s && mrd_s;

  // Only strobes returning to idle close a latched cycle; the gap
  // between latch strobe and read or write strobe is all idle
  // Limitation: a latch with no strobe after it stays in use
  // capture on strobe falling edge
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ale_q      <= 1'b1;
      stb_idle_q <= 1'b1;
      a_lat      <= {ADDR_W{1'b0}};
      ube_lat    <= 1'b1;
      lat_valid  <= 1'b0;
    end else begin
      ale_q      <= ale_s;
      stb_idle_q <= stb_idle;
      if (ale_q && !ale_s) begin
        a_lat     <= a_s;
        ube_lat   <= ube_s;
        lat_valid <= 1'b1;
      end else if (stb_idle && !stb_idle_q) begin
        lat_valid <= 1'b0;          // Cycle over, fall back to live lines
      end
    end
  end

  // Latched values win while a latched cycle is open
  wire [ADDR_W-1:0] a_use   = lat_valid ? a_lat : a_s;
  wire              ube_use = lat_valid ? ube_lat : ube_s;

  // =========================================================
  // Decode
  // =========================================================
  // qualifier low enables decode
  wire io_hit  = !aen_s && local_bus_mode_o &&
                 (a_use[`LBHPI_BASE_MSB:`LBHPI_BASE_LSB] == base_addr_i);
  wire wide_hit = io_hit && wide_mode_i;
  // Memory cycles are qualified like I/O cycles
  // ROM window in top address nibble
  wire rom_hit = !aen_s && local_bus_mode_o && !mrd_s && (a_use[ADDR_W-1 -: 4] == rom_base_i);

  wire io_rd   = io_hit && !rd_s;
  wire io_wr   = io_hit && !wr_s;
  // Word index from A3:A1; A0 steers the byte lane
  wire [IDX_W-1:0] idx = a_use[IDX_W:1];

  // =========================================================
  // Register file behind the data path
  // =========================================================
  reg [DATA_W-1:0] regs [0:(1<<IDX_W)-1];
  integer          i;

  // Stand-in for the core registers; filtered reset clears them
  // Odd address with upper enable puts the low lane in the upper byte
  // writes while strobe held; upper byte per enable
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (i = 0; i < (1<<IDX_W); i = i + 1) begin
        regs[i] <= {DATA_W{1'b0}};
      end
    end else begin
      if (rst_f) begin
        for (i = 0; i < (1<<IDX_W); i = i + 1) begin
          regs[i] <= {DATA_W{1'b0}};
        end
      end else if (io_wr) begin
        if (!a_use[0]) begin
          regs[idx][7:0] <= d_s[7:0];
        end
        if (!ube_use) begin
          regs[idx][15:8] <= a_use[0] ? d_s[7:0] : d_s[15:8];
        end
      end
    end
  end

  // =========================================================
  // Wait states
  // =========================================================
  reg [3:0] wait_cnt;
  reg       acc_q;
  wire      acc = io_rd || io_wr;

  // Only the first cycle of an access loads the counter, so a
  // strobe held long after release is not stretched twice
  // Fixed count; a real core would hold ready until data is ready
  // Counter width covers any wait count up to fifteen
  // hold ready low for a fixed count
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_q                  <= 1'b0;
      wait_cnt               <= 4'h0;
      channel_ready_out_oe_o <= 1'b0;
    end else begin
      acc_q <= acc;
      if (acc && !acc_q) begin
        wait_cnt               <= `LBHPI_WAIT_CYC;
        channel_ready_out_oe_o <= 1'b1;
      end else if (wait_cnt != 4'h0) begin
        wait_cnt <= wait_cnt - 4'h1;
      end else begin
        channel_ready_out_oe_o <= 1'b0;   // Release; host may end cycle
      end
    end
  end

  // =========================================================
  // Output drivers
  // =========================================================
  // Read data is registered every cycle; the enable gates the pins
  // Wide cycle indicate follows the decode alone, ahead of strobes
  // Strap pin is driven only outside reset, so the board pull is
  // what the strap capture sees
  // read data with byte steering; wide cycle; ROM select
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_o                     <= {DATA_W{1'b0}};
      data_oe_o                  <= 1'b0;
      wide_cycle_indicate_n_oe_o <= 1'b0;
      rom_select_strap_o         <= 1'b1;
      rom_select_strap_oe_o      <= 1'b0;
    end else begin
      data_o                     <= a_use[0] ? {8'h00, regs[idx][15:8]} : regs[idx];
      data_oe_o                  <= io_rd;
      wide_cycle_indicate_n_oe_o <= wide_hit;
      rom_select_strap_o         <= !rom_hit;
      rom_select_strap_oe_o      <= local_bus_mode_o && !rst_f;
    end
  end

  // =========================================================
  // Interrupt routing
  // =========================================================
  // Select decoded per line, one compare each
  // Exactly one enable is high for any select value
  // one line driven, others released
  generate
    for (g = 0; g < `LBHPI_INT_LINES; g = g + 1) begin : g_int
      always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          interrupt_out_o[g]    <= 1'b0;
          interrupt_out_oe_o[g] <= 1'b0;
        end else begin
          interrupt_out_oe_o[g] <= (interrupt_line_select_i == g);
          interrupt_out_o[g]    <= (interrupt_line_select_i == g) && core_irq_i;
        end
      end
    end
  endgenerate

endmodule

// ===== lbhpi_chk.sv
// Port checker for the local bus host pin interface
`timescale 1ns/1ps
module lbhpi_chk #(
  parameter ADDR_W = 20
) (
  // Clock and reset
  input wire              clk_i,
  input wire              rst_n_i,
  // Host pins
  input wire              reset_pin_i,
  input wire [ADDR_W-1:0] addr_i,
  input wire              address_qualifier_i,
  input wire              io_read_n_i,
  input wire              memory_read_strobe_n_i,
  // Device pin drives
  input wire              data_oe_o,
  input wire              rom_select_strap_o,
  input wire              rom_select_strap_oe_o,
  input wire              channel_ready_out_oe_o,
  input wire              wide_cycle_indicate_n_oe_o,
  // Core side
  input wire              wide_mode_i,
  input wire [11:0]       base_addr_i,
  input wire [3:0]        rom_base_i,
  input wire [1:0]        interrupt_line_select_i,
  input wire              core_irq_i,
  input wire [3:0]        interrupt_out_o,
  input wire [3:0]        interrupt_out_oe_o,
  input wire              local_bus_mode_o,
  input wire              chip_reset_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Live decode; latched cycles simply leave it false
  wire hit = !address_qualifier_i && addr_i[15:4] == base_addr_i;
  wire rom = !address_qualifier_i && !memory_read_strobe_n_i && addr_i[19:16] == rom_base_i && local_bus_mode_o;
  reg  [5:0] hi_cnt;
  // Run length of the raw reset pin, saturating
  always @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i) hi_cnt <= 6'h00;
    else hi_cnt <= !reset_pin_i ? 6'h00 : (hi_cnt == 6'h3f ? hi_cnt : hi_cnt + 6'h01);

  chk_rst_filter: assert property ($rose(chip_reset_o) |-> hi_cnt >= 6'd20) else $error("reset glitch passed");
  chk_rst_release: assert property (!reset_pin_i [*6] |-> !chip_reset_o) else $error("reset stuck");
  chk_rom_select: assert property (rom [*4] |-> rom_select_strap_oe_o && !rom_select_strap_o) else $error("rom");
  chk_rom_idle: assert property (memory_read_strobe_n_i [*4] |-> !(rom_select_strap_oe_o && !rom_select_strap_o))
    else $error("rom without read");
  chk_qual_quiet: assert property (address_qualifier_i [*5] |-> !data_oe_o && !wide_cycle_indicate_n_oe_o)
    else $error("drive while unqualified");
  chk_read_drive: assert property ((!io_read_n_i && hit) [*4] |-> data_oe_o) else $error("read not driven");
  chk_wait_stretch: assert property ($fell(io_read_n_i) && hit |-> ##[1:4] channel_ready_out_oe_o
    ##[1:6] !channel_ready_out_oe_o) else $error("wait shape");
  chk_wide_cycle: assert property ((wide_mode_i && hit) [*4] |-> wide_cycle_indicate_n_oe_o) else $error("wide");
  chk_int_route: assert property ((!chip_reset_o && $stable(interrupt_line_select_i)) [*3]
    |-> interrupt_out_oe_o == 4'h1 << interrupt_line_select_i) else $error("int route");
  chk_int_level: assert property ((!chip_reset_o && $stable(core_irq_i)) [*3] |->
    (interrupt_out_o & interrupt_out_oe_o) == ({4{core_irq_i}} & interrupt_out_oe_o)) else $error("int level");
endmodule

bind lbhpi_top lbhpi_chk #(.ADDR_W(ADDR_W)) u_chk (.clk_i, .rst_n_i, .reset_pin_i, .addr_i, .address_qualifier_i,
  .io_read_n_i, .memory_read_strobe_n_i, .data_oe_o, .rom_select_strap_o, .rom_select_strap_oe_o,
  .channel_ready_out_oe_o, .wide_cycle_indicate_n_oe_o, .wide_mode_i, .base_addr_i, .rom_base_i,
  .interrupt_line_select_i, .core_irq_i, .interrupt_out_o, .interrupt_out_oe_o, .local_bus_mode_o, .chip_reset_o);

// ===== lbhpi_host.sv
// Host processor model driving the local bus pins
`timescale 1ns/1ps
module lbhpi_host (
  // Clock and device drives
  input  wire         clk_i,
  input  wire  [15:0] dev_data_i,
  input  wire         dev_oe_i,
  input  wire         dev_wait_i,
  // Host pins
  output logic [19:0] addr_o,
  output logic        qual_o,
  output logic        ale_o,
  output logic        ube_n_o,
  output logic        ior_n_o,
  output logic        iow_n_o,
  output logic        memr_n_o,
  output wire  [15:0] data_pin_o
);
  logic        drv = 1'b0;
  logic [15:0] wd = 16'h0000;
  logic [15:0] rdata;
  logic        tmo = 1'b0;
  // Weak pullups win when nobody drives
  assign data_pin_o = dev_oe_i ? dev_data_i : (drv ? wd : 16'hffff);
  // Idle bus: unqualified, strobes high
  initial {addr_o, qual_o, ale_o, ube_n_o, ior_n_o, iow_n_o, memr_n_o} = {20'h00000, 6'h3f};

  // One I/O cycle, optionally address-latched
  task cyc(input logic q, rd, input logic [19:0] a, input logic ube, lat, input logic [15:0] d);
    int n;
    @(posedge clk_i) #1;
    addr_o = a;
    // qualifier and byte enable per transfer
    qual_o = q;
    ube_n_o = ube;
    ale_o = lat;
    if (lat) begin
      @(posedge clk_i) #1;
      ale_o = 1'b0;
      repeat (3) @(posedge clk_i);
      #1;
      // Scramble lines so only the latched copy is valid
      addr_o = ~a;
      ube_n_o = ~ube;
    end
    wd = d;
    drv = !rd;
    ior_n_o = !rd;
    iow_n_o = rd;
    repeat (4) @(posedge clk_i);
    #1;
    // hold the strobe until wait is released
    for (n = 0; n < 40 && dev_wait_i; n++) begin
      @(posedge clk_i);
      #1;
    end
    tmo = dev_wait_i;
    rdata = data_pin_o;
    {ior_n_o, iow_n_o, qual_o, drv} = 4'he;
    addr_o = ~addr_o;
    repeat (6) @(posedge clk_i);
    #1;
  endtask
endmodule

// ===== lbhpi_bench.sv
// Self-checking bench for the local bus host pin interface
`timescale 1ns/1ps
`include "lbhpi_defs.vh"
module lbhpi_bench;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        reset_pin_i = 1'b0;
  logic        pull = 1'b1;
  logic [1:0]  sel = 2'h0;
  logic        irq = 1'b0;
  logic        wide = 1'b1;
  int          n_wide = 0;
  int          n_wait = 0;
  wire  [19:0] addr;
  wire  [15:0] dpin, dout;
  wire  [3:0]  int_o, int_oe;
  wire         qual, ale, ube_n, ior_n, iow_n, memr_n, doe, rs_o, rs_oe, rdy_oe, lbm, crst, wide_oe;
  int          miscompares = 0;
  int          n_tests = 0;
  // Strap pin: device drive or board pull
  wire strap = rs_oe ? rs_o : pull;

  always #2.5 clk_i = ~clk_i;

  // Cycle counts of outputs that stand only inside a host cycle
  always @(posedge clk_i) begin
    n_wide <= n_wide + wide_oe;
    n_wait <= n_wait + rdy_oe;
  end

  lbhpi_top u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .reset_pin_i(reset_pin_i), .addr_i(addr),
    .address_qualifier_i(qual), .address_latch_strobe_i(ale), .upper_byte_enable_n_i(ube_n), .io_read_n_i(ior_n),
    .io_write_n_i(iow_n), .memory_read_strobe_n_i(memr_n), .data_i(dpin), .data_o(dout), .data_oe_o(doe),
    .rom_select_strap_i(strap), .rom_select_strap_o(rs_o), .rom_select_strap_oe_o(rs_oe),
    .channel_ready_out_oe_o(rdy_oe), .wide_cycle_indicate_n_oe_o(wide_oe), .wide_mode_i(wide), .base_addr_i(12'h030),
    .rom_base_i(4'hc), .interrupt_line_select_i(sel), .core_irq_i(irq), .interrupt_out_o(int_o),
    .interrupt_out_oe_o(int_oe), .local_bus_mode_o(lbm), .chip_reset_o(crst));

  lbhpi_host u_host (.clk_i(clk_i), .dev_data_i(dout), .dev_oe_i(doe), .dev_wait_i(rdy_oe), .addr_o(addr),
    .qual_o(qual), .ale_o(ale), .ube_n_o(ube_n), .ior_n_o(ior_n), .iow_n_o(iow_n), .memr_n_o(memr_n),
    .data_pin_o(dpin));

  task tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task chk(input logic [19:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task wrap_up;
    if (miscompares == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Host cycle with read-back compare; a stuck wait ends the run
  task acc(input logic q, rd, input logic [19:0] a, input logic ube, lat, input logic [15:0] d, e);
    int   w0;
    int   r0;
    logic hit;
    hit = !q && (a[15:4] == 12'h030);
    w0 = n_wide;
    r0 = n_wait;
    u_host.cyc(q, rd, a, ube, lat, d);
    if (u_host.tmo) begin
      miscompares++;
      wrap_up;
    end
    if (rd) chk(u_host.rdata, e);
    chk(n_wide != w0, hit && wide);
    chk(n_wait - r0, hit ? `LBHPI_WAIT_CYC + 4'h1 : 4'h0);
  endtask

  // Glitch, real reset, strap sample
  task t_reset(input logic s);
    int i;
    pull = s;
    reset_pin_i = 1'b1;
    tick(10);
    reset_pin_i = 1'b0;
    tick(30);
    chk(crst, 0);
    reset_pin_i = 1'b1;
    for (i = 0; i < 40 && crst !== 1'b1; i++) tick(1);
    chk(crst, 1);
    if (crst !== 1'b1) wrap_up;
    tick(10);
    reset_pin_i = 1'b0;
    tick(10);
    chk(crst, 0);
    chk(lbm, s);
  endtask

  // Byte lanes, refusals and latched address
  task t_regs;
    acc(0, 0, 20'h00304, 0, 0, 16'h1234, 0);
    acc(0, 1, 20'h00304, 0, 0, 0, 16'h1234);
    acc(0, 0, 20'h00304, 1, 0, 16'h55ab, 0);
    acc(0, 0, 20'h00305, 0, 0, 16'h00cd, 0);
    acc(0, 1, 20'h00304, 0, 0, 0, 16'hcdab);
    acc(1, 0, 20'h00304, 0, 0, 16'hdead, 0);
    acc(0, 0, 20'h00404, 0, 0, 16'hbeef, 0);
    acc(0, 1, 20'h00304, 0, 0, 0, 16'hcdab);
    acc(0, 0, 20'h0030e, 0, 1, 16'h9a7c, 0);
    acc(0, 1, 20'h0030e, 0, 1, 0, 16'h9a7c);
    acc(0, 1, 20'h0030e, 0, 0, 0, 16'h9a7c);
    wide = 1'b0;
    acc(0, 1, 20'h0030e, 0, 0, 0, 16'h9a7c);
    wide = 1'b1;
  endtask

  // Every select value, interrupt raised and dropped
  task t_irq;
    int s;
    for (s = 0; s < 4; s++) begin
      sel = s[1:0];
      irq = 1'b1;
      tick(4);
      chk(int_oe, 4'h1 << s);
      chk(int_o & int_oe, 4'h1 << s);
      irq = 1'b0;
      tick(4);
      chk(int_o & int_oe, 0);
    end
  endtask

  // Boot ROM select on upper address match only
  task t_rom;
    u_host.qual_o = 1'b0;
    u_host.addr_o = 20'hc1234;
    u_host.memr_n_o = 1'b0;
    tick(5);
    chk({rs_oe, strap}, 2'b10);
    u_host.addr_o = 20'h41234;
    tick(5);
    chk(strap, 1);
    u_host.addr_o = 20'hc1234;
    u_host.qual_o = 1'b1;
    tick(5);
    chk(strap, 1);
    u_host.memr_n_o = 1'b1;
    tick(5);
  endtask

  initial begin
    tick(10);
    rst_n_i = 1'b1;
    tick(2);
    t_reset(0);
    t_reset(1);
    t_regs;
    t_irq;
    t_rom;
    wrap_up;
  end
endmodule
